/* File: core/pdt_pkg.sv */
package pdt_pkg;

  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_IVAL_IRQ  = 4'h1;
  localparam logic [3:0] IDX_RLD_IRQ   = 4'h2;
  localparam logic [3:0] IDX_IVAL_MODE = 4'h8;
  localparam logic [3:0] IDX_RLD_MODE  = 4'h9;
  localparam logic [3:0] IDX_RLD_LOW   = 4'ha;
  localparam logic [3:0] IDX_RLD_HIGH  = 4'hb;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IVAL_FLAG_BIT  = 2;
  localparam int IVAL_MASK_BIT  = 3;
  localparam int RLD_FLAG_BIT   = 0;
  localparam int RLD_MASK_BIT   = 1;
  localparam int RLD_AUTO_BIT   = 3;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int PRESC_W = 11;
  localparam int CNT_W   = 8;
  localparam logic [PRESC_W-1:0] PRESC_RST     = 11'h000;
  localparam logic [CNT_W-1:0]   CNT_RST       = 8'h00;
  localparam logic [CNT_W-1:0]   CNT_MAX       = 8'hff;
  localparam logic [2:0]         IVAL_MODE_RST = 3'h0;
  localparam logic [3:0]         RLD_MODE_RST  = 4'h0;
  localparam logic               MASK_RST      = 1'b1;
  localparam logic [2:0]         RLD_SRC_EVENT = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int        INSTR_CYC_NS   = 10;
  localparam int        CLK_PERIOD_NS  = 10;
  localparam int        INSTR_CYC      = (INSTR_CYC_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
  localparam logic [1:0] MODE_DLY      = 2'(2 * INSTR_CYC);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mask;
    logic flag;
  } pdt_irq_type;

  typedef struct packed {
    logic       auto_reload;
    logic [2:0] source;
  } pdt_rld_mode_type;

endpackage

/* File: core/pdt_timer.sv */
`timescale 1ns/10ps
module pdt_timer
  import pdt_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  input  wire logic        stop_i,
  input  wire logic        event_input_i,
  output logic             interval_irq_o,
  output logic             reload_irq_o
);

  // ----------------------------------------------------------------
  // Tap decode
  // ----------------------------------------------------------------
  // Tap for divide 2**k fires once per 2**k clocks
  function automatic logic tap_fire(input logic [PRESC_W-1:0] p,
                                    input logic [3:0] k);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((12'h001 << k) - 12'h001);
    return (p & m) == m;
  endfunction

  function automatic logic [3:0] ival_exp(input logic [2:0] c);
    logic [3:0] e;
    unique case (c)
      3'h0: e = 4'hb;
      3'h1: e = 4'ha;
      3'h2: e = 4'h9;
      3'h3: e = 4'h7;
      3'h4: e = 4'h5;
      3'h5: e = 4'h3;
      3'h6: e = 4'h2;
      3'h7: e = 4'h1;
    endcase
    return e;
  endfunction

  function automatic logic [3:0] rld_exp(input logic [2:0] c);
    logic [3:0] e;
    unique case (c)
      3'h0: e = 4'hb;
      3'h1: e = 4'h9;
      3'h2: e = 4'h7;
      3'h3: e = 4'h5;
      3'h4: e = 4'h3;
      3'h5: e = 4'h2;
      3'h6: e = 4'h1;
      3'h7: e = 4'h1;
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic                     ack_reg;
  logic                     do_wr;
  logic                     do_rd;
  logic                     lane0;
  logic [3:0]               idx;
  logic [3:0]               wnib;
  logic [PRESC_W-1:0]       presc_reg;
  logic [CNT_W-1:0]         ival_reg;
  logic [CNT_W-1:0]         rld_reg;
  logic [CNT_W-1:0]         preset_reg;
  logic [3:0]               latch_reg;
  logic [2:0]               ival_mode_reg;
  pdt_rld_mode_type         rld_mode_reg;
  pdt_rld_mode_type         rld_pend_reg;
  logic [1:0]               mode_dly_reg;
  pdt_irq_type              ival_irq_reg;
  pdt_irq_type              rld_irq_reg;
  logic [31:0]              rdata_next;
  logic                     ev_s1_reg;
  logic                     ev_s2_reg;
  logic                     ev_d_reg;
  logic                     ev_fall;
  logic                     ival_tick;
  logic                     rld_tick;
  logic                     ival_ovf;
  logic                     rld_ovf;
  logic                     load_hi;

  // One wait cycle keeps read data registered and side effects single
  assign waitrequest_o = (read_i | write_i) & ~ack_reg;
  assign do_wr         = write_i & ack_reg;
  assign do_rd         = read_i & ack_reg & ~write_i;
  assign idx           = address_i[5:2];
  assign lane0         = byteenable_i[0];
  assign wnib          = writedata_i[3:0];

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read_i | write_i) & ~ack_reg;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (idx)
      IDX_IVAL_IRQ: begin
        rdata_next[IVAL_FLAG_BIT] = ival_irq_reg.flag;
        rdata_next[IVAL_MASK_BIT] = ival_irq_reg.mask;
      end
      IDX_RLD_IRQ: begin
        rdata_next[RLD_FLAG_BIT] = rld_irq_reg.flag;
        rdata_next[RLD_MASK_BIT] = rld_irq_reg.mask;
      end
      IDX_RLD_LOW:  rdata_next[3:0] = latch_reg;
      IDX_RLD_HIGH: rdata_next[3:0] = rld_reg[7:4];
      default:      rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i & ~ack_reg) begin
      readdata_o <= rdata_next;
    end
  end

  // high read latches low nibble
  // Taken with the high nibble so both halves share one count
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_reg <= 4'h0;
    end else if (read_i && !write_i && !ack_reg && idx == IDX_RLD_HIGH) begin
      latch_reg <= rld_reg[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and taps
  // ----------------------------------------------------------------
  // cleared by reset, halts only in stop mode
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_reg <= PRESC_RST;
    end else if (!stop_i) begin
      presc_reg <= presc_reg + 11'h001;
    end
  end

  // event pin synchronised, falling edge on second stage
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_s1_reg <= 1'b1;
      ev_s2_reg <= 1'b1;
      ev_d_reg  <= 1'b1;
    end else begin
      ev_s1_reg <= event_input_i;
      ev_s2_reg <= ev_s1_reg;
      ev_d_reg  <= ev_s2_reg;
    end
  end
  assign ev_fall = ev_d_reg & ~ev_s2_reg;

  assign ival_tick = !stop_i && tap_fire(presc_reg, ival_exp(ival_mode_reg));
  // reload source select, code 7 event edge, codes 0 to 6 taps
  assign rld_tick  = (rld_mode_reg.source == RLD_SRC_EVENT) ? ev_fall :
                     (!stop_i &&
                      tap_fire(presc_reg, rld_exp(rld_mode_reg.source)));

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  // write-only, reset to zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ival_mode_reg <= IVAL_MODE_RST;
    end else if (do_wr && lane0 && idx == IDX_IVAL_MODE) begin
      ival_mode_reg <= wnib[2:0];
    end
  end

  // mode applies after a short delay
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rld_pend_reg <= RLD_MODE_RST;
      mode_dly_reg <= 2'h0;
    end else if (do_wr && lane0 && idx == IDX_RLD_MODE) begin
      rld_pend_reg <= wnib;
      mode_dly_reg <= MODE_DLY;
    end else if (mode_dly_reg != 2'h0) begin
      mode_dly_reg <= mode_dly_reg - 2'h1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rld_mode_reg <= RLD_MODE_RST;
    end else if (mode_dly_reg == 2'h1) begin
      rld_mode_reg <= rld_pend_reg;
    end
  end

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------
  assign ival_ovf = ival_tick && ival_reg == CNT_MAX;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ival_reg <= CNT_RST;
    end else if (ival_tick) begin
      ival_reg <= ival_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Reload counter and preset
  // ----------------------------------------------------------------
  assign load_hi = do_wr && lane0 && idx == IDX_RLD_HIGH;
  assign rld_ovf = rld_tick && rld_reg == CNT_MAX && !load_hi;

  // preset cleared by reset; nibble writes
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      preset_reg <= CNT_RST;
    end else if (do_wr && lane0 && idx == IDX_RLD_LOW) begin
      preset_reg[3:0] <= wnib;
    end else if (load_hi) begin
      preset_reg[7:4] <= wnib;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rld_reg <= CNT_RST;
    end else if (load_hi) begin
      rld_reg <= {wnib, preset_reg[3:0]};
    end else if (rld_ovf) begin
      rld_reg <= rld_mode_reg.auto_reload ? preset_reg : CNT_RST;
    end else if (rld_tick) begin
      rld_reg <= rld_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Request flags and masks
  // ----------------------------------------------------------------
  // overflow sets flag; set wins over a clearing write
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ival_irq_reg <= '{mask: MASK_RST, flag: 1'b0};
    end else begin
      if (do_wr && lane0 && idx == IDX_IVAL_IRQ) begin
        ival_irq_reg.mask <= wnib[IVAL_MASK_BIT];
        ival_irq_reg.flag <= ival_ovf | wnib[IVAL_FLAG_BIT];
      end else if (ival_ovf) begin
        ival_irq_reg.flag <= 1'b1;
      end
    end
  end

  // overflow sets flag; set wins over a clearing write
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rld_irq_reg <= '{mask: MASK_RST, flag: 1'b0};
    end else begin
      if (do_wr && lane0 && idx == IDX_RLD_IRQ) begin
        rld_irq_reg.mask <= wnib[RLD_MASK_BIT];
        rld_irq_reg.flag <= rld_ovf | wnib[RLD_FLAG_BIT];
      end else if (rld_ovf) begin
        rld_irq_reg.flag <= 1'b1;
      end
    end
  end

  assign interval_irq_o = ival_irq_reg.flag & ~ival_irq_reg.mask;
  assign reload_irq_o   = rld_irq_reg.flag & ~rld_irq_reg.mask;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence mode_write_s;
    do_wr && lane0 && idx == IDX_RLD_MODE;
  endsequence

  sequence quiet_bus_s;
    !(do_wr && idx == IDX_RLD_MODE) [*2];
  endsequence

  a_presc_runs: assert property (
    nrst_i && !stop_i |=> presc_reg == PRESC_W'($past(presc_reg) + 11'h001))
    else $error("prescaler did not advance");

  a_presc_holds: assert property (
    stop_i |=> presc_reg == $past(presc_reg))
    else $error("prescaler moved in stop mode");

  a_ival_wrap: assert property (
    ival_tick && ival_reg == CNT_MAX |=> ival_reg == CNT_RST
      && ival_irq_reg.flag)
    else $error("interval wrap or flag wrong");

  a_ival_div2: assert property (
    ival_tick && ival_mode_reg == 3'h7 && !stop_i
      |=> !ival_tick ##1 ival_tick)
    else $error("divide by two tap wrong");

  a_rld_reload: assert property (
    rld_ovf |=> rld_reg == ($past(rld_mode_reg.auto_reload) ?
      $past(preset_reg) : CNT_RST) && rld_irq_reg.flag)
    else $error("reload overflow value wrong");

  a_mode_delay: assert property (
    mode_write_s ##1 quiet_bus_s
      |=> rld_mode_reg == pdt_rld_mode_type'($past(wnib, 3)))
    else $error("reload mode not applied on time");

  a_preset_load: assert property (
    load_hi |=> rld_reg == {$past(wnib), preset_reg[3:0]})
    else $error("high preset write did not load");

  a_low_latch: assert property (
    do_rd && idx == IDX_RLD_HIGH
      |-> {readdata_o[3:0], latch_reg} == $past(rld_reg))
    else $error("count halves not taken together");

  a_flag_sticky: assert property (
    ival_irq_reg.flag && !(do_wr && idx == IDX_IVAL_IRQ)
      |=> ival_irq_reg.flag)
    else $error("interval flag cleared by hardware");

  a_event_count: assert property (
    rld_mode_reg.source == RLD_SRC_EVENT && !rld_tick && !load_hi
      |=> rld_reg == $past(rld_reg))
    else $error("reload counted without event edge");

  a_irq_gate: assert property (
    rld_ovf && !rld_irq_reg.mask && !(do_wr && idx == IDX_RLD_IRQ)
      |=> reload_irq_o)
    else $error("unmasked reload request missing");

endmodule

/* File: dv/test_pdt_timer.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_pdt_timer
  import pdt_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic        clock_i = 1'b0;
  logic        nrst_i;
  logic [5:0]  address_i;
  logic        read_i;
  logic        write_i;
  logic [3:0]  byteenable_i;
  logic [31:0] writedata_i;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        stop_i;
  logic        event_input_i;
  logic        interval_irq_o;
  logic        reload_irq_o;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  int          ival_div [8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};
  int          rld_div [7] = '{2048, 512, 128, 32, 8, 4, 2};

  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;

  pdt_timer i_dut (
    .clock_i       (clock_i),
    .nrst_i        (nrst_i),
    .address_i     (address_i),
    .read_i        (read_i),
    .write_i       (write_i),
    .byteenable_i  (byteenable_i),
    .writedata_i   (writedata_i),
    .readdata_o    (readdata_o),
    .waitrequest_o (waitrequest_o),
    .stop_i        (stop_i),
    .event_input_i (event_input_i),
    .interval_irq_o(interval_irq_o),
    .reload_irq_o  (reload_irq_o)
  );

  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input bit wr_en, input logic [3:0] idx,
                     input logic [3:0] d, output logic [3:0] q);
    int n;
    n = 0;
    address_i <= {idx, 2'b00};
    writedata_i <= {28'h0, d};
    write_i <= wr_en;
    read_i <= !wr_en;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) n_fail++;
    q = readdata_o[3:0];
    write_i <= 1'b0;
    read_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [3:0] d);
    logic [3:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [3:0] e);
    logic [3:0] q;
    bus(1'b0, idx, 4'h0, q);
    `CHK(q, e)
  endtask

  // Cycle stamp of the next request; both stamps share one phase
  task automatic wait_irq(input bit rld, output int t);
    int n;
    n = 0;
    #1;
    while ((rld ? reload_irq_o : interval_irq_o) !== 1'b1 && n < 40000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= 40000) n_fail++;
    t = cyc;
    @(posedge clock_i);
  endtask

  task automatic ev_pulse();
    event_input_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    event_input_i <= 1'b1;
    repeat (4) @(posedge clock_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK(interval_irq_o, 1'b0)
    `CHK(reload_irq_o, 1'b0)
    rd(IDX_IVAL_IRQ, 4'h8);
    rd(IDX_RLD_IRQ, 4'h2);
    rd(IDX_IVAL_MODE, 4'h0);
    rd(IDX_RLD_MODE, 4'h0);
    rd(4'hf, 4'h0);
    rd(IDX_RLD_HIGH, 4'h0);
    rd(IDX_RLD_LOW, 4'h0);
    $display("reset test done");
  endtask

  // Stop freezes the taps so the count is known at each read
  task automatic t_latch();
    stop_i <= 1'b1;
    wr(IDX_RLD_MODE, 4'h6);
    wr(IDX_RLD_LOW, 4'h5);
    wr(IDX_RLD_HIGH, 4'ha);
    repeat (50) @(posedge clock_i);
    rd(IDX_RLD_HIGH, 4'ha);
    wr(IDX_RLD_LOW, 4'hc);
    wr(IDX_RLD_HIGH, 4'h3);
    rd(IDX_RLD_LOW, 4'h5);
    rd(IDX_RLD_HIGH, 4'h3);
    rd(IDX_RLD_LOW, 4'hc);
    stop_i <= 1'b0;
    $display("latch test done");
  endtask

  task automatic t_event();
    wr(IDX_RLD_MODE, 4'h7);
    wr(IDX_RLD_LOW, 4'he);
    wr(IDX_RLD_HIGH, 4'hf);
    wr(IDX_RLD_IRQ, 4'h2);
    ev_pulse();
    rd(IDX_RLD_HIGH, 4'hf);
    rd(IDX_RLD_LOW, 4'hf);
    ev_pulse();
    rd(IDX_RLD_IRQ, 4'h3);
    `CHK(reload_irq_o, 1'b0)
    rd(IDX_RLD_HIGH, 4'h0);
    rd(IDX_RLD_LOW, 4'h0);
    $display("event test done");
  endtask

  task automatic t_reload();
    int         t0;
    int         t1;
    logic [7:0] p;
    wr(IDX_RLD_IRQ, 4'h0);
    for (int c = 0; c < 7; c++) begin
      p = (rld_div[c] >= 128) ? 8'hfc : 8'hc0;
      wr(IDX_RLD_MODE, 4'h8 | 4'(c));
      wr(IDX_RLD_LOW, p[3:0]);
      wr(IDX_RLD_HIGH, p[7:4]);
      wait_irq(1'b1, t0);
      wr(IDX_RLD_IRQ, 4'h0);
      wait_irq(1'b1, t1);
      wr(IDX_RLD_IRQ, 4'h0);
      `CHK(t1 - t0, (256 - int'(p)) * rld_div[c])
    end
    // Without reload the count restarts from zero
    wr(IDX_RLD_MODE, 4'h6);
    wait_irq(1'b1, t0);
    wr(IDX_RLD_IRQ, 4'h0);
    wait_irq(1'b1, t1);
    `CHK(t1 - t0, 256 * 2)
    wr(IDX_RLD_IRQ, 4'h2);
    $display("reload test done");
  endtask

  // Slow codes skipped: one period at divide 128 or more is too long
  task automatic t_interval();
    int t0;
    int t1;
    wr(IDX_IVAL_IRQ, 4'h0);
    for (int c = 4; c < 8; c++) begin
      wr(IDX_IVAL_MODE, 4'(c));
      wait_irq(1'b0, t0);
      wr(IDX_IVAL_IRQ, 4'h0);
      wait_irq(1'b0, t1);
      wr(IDX_IVAL_IRQ, 4'h0);
      `CHK(t1 - t0, 256 * ival_div[c])
    end
    wait_irq(1'b0, t0);
    wr(IDX_IVAL_IRQ, 4'hc);
    `CHK(interval_irq_o, 1'b0)
    rd(IDX_IVAL_IRQ, 4'hc);
    $display("interval test done");
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    nrst_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 6'h00;
    writedata_i = 32'h0;
    byteenable_i = 4'h1;
    stop_i = 1'b0;
    event_input_i = 1'b1;
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_latch();
    t_event();
    t_reload();
    t_interval();
    wrap_up();
  end

  // Well above the expected run of some 55000 cycles
  initial begin
    #900000;
    n_fail++;
    wrap_up();
  end
endmodule
